// ### hw/bpsc_pkg.sv
`default_nettype none
package bpsc_pkg;
  // Light-load cycles needed before PFM entry
  localparam int unsigned LIGHT_CYCLES = 32;
  localparam int unsigned LIGHT_CNT_W = 6;
  localparam logic [LIGHT_CNT_W-1:0] LIGHT_CNT_MAX = 6'h20;
  localparam logic [LIGHT_CNT_W-1:0] LIGHT_CNT_RST = 6'h00;
  // Oscillator clock per PWM cycle, clock 40 MHz, PWM tick rate set by divider
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned PWM_KHZ = 3000;
  localparam int unsigned TICK_DIV = (CLK_MHZ * 1000 + PWM_KHZ - 1) / PWM_KHZ;
  localparam int unsigned TICK_W = 4;
  localparam logic [TICK_W-1:0] TICK_LAST = 4'(TICK_DIV - 1);
  localparam logic [TICK_W-1:0] TICK_RST = 4'h0;
  // Soft-start current limit steps in mA
  localparam int unsigned ILIM_STEP0_MA = 200;
  localparam int unsigned ILIM_STEP1_MA = 400;
  localparam int unsigned ILIM_STEP2_MA = 600;
  localparam int unsigned ILIM_FULL_MA = 1220;
  // Soft-start step codes on the limit select output
  localparam logic [1:0] ILIM_SEL_200 = 2'h0;
  localparam logic [1:0] ILIM_SEL_400 = 2'h1;
  localparam logic [1:0] ILIM_SEL_600 = 2'h2;
  localparam logic [1:0] ILIM_SEL_FULL = 2'h3;
  // PWM cycles spent at each soft-start step
  localparam int unsigned SS_STEP_CYCLES = 16;
  localparam int unsigned SS_CNT_W = 5;
  localparam logic [SS_CNT_W-1:0] SS_CNT_LAST = 5'(SS_STEP_CYCLES - 1);
  localparam logic [SS_CNT_W-1:0] SS_CNT_RST = 5'h00;
  // Pass device ratings, mA
  localparam int unsigned SMALL_PASS_MA = 50;
  localparam int unsigned LARGE_PASS_MA = 350;

  typedef enum logic [2:0] {
    BPSC_OFF = 3'b000,
    BPSC_PWM_HS = 3'b001,
    BPSC_PWM_LS = 3'b011,
    BPSC_LIMIT = 3'b010,
    BPSC_PFM_HS = 3'b110,
    BPSC_PFM_LS = 3'b111,
    BPSC_PFM_PARK = 3'b101,
    BPSC_SLEEP = 3'b100
  } bpsc_state_t;
endpackage
`default_nettype wire

// ### hw/bpsc_cmp_if.sv
`timescale 1ns/100ps
`default_nettype none
interface bpsc_cmp_if;
  logic tick;
  logic cycle_start;
  logic light_cycle;
  logic pfm_ok;
  modport timer (output tick, input cycle_start, input light_cycle, output pfm_ok);
  modport core (input tick, output cycle_start, output light_cycle, input pfm_ok);
endinterface
`default_nettype wire

// ### hw/bpsc_tick_gen.sv
`timescale 1ns/100ps
`default_nettype none
module bpsc_tick_gen
  import bpsc_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic run_i,
  bpsc_cmp_if.timer cmp
);
  logic [TICK_W-1:0] div_q;
  logic [TICK_W-1:0] div_d;
  logic [LIGHT_CNT_W-1:0] light_q;
  logic [LIGHT_CNT_W-1:0] light_d;
  logic div_wrap;
  logic light_full;

  assign div_wrap = (div_q == TICK_LAST);
  assign div_d = (!run_i || div_wrap) ? TICK_RST : div_q + 4'h1;
  assign cmp.tick = run_i && div_wrap;
  assign light_full = (light_q == LIGHT_CNT_MAX);
  // Any heavy cycle restarts the count [R17]
  assign light_d = !run_i ? LIGHT_CNT_RST :
                   !cmp.cycle_start ? light_q :
                   !cmp.light_cycle ? LIGHT_CNT_RST :
                   light_full ? light_q : light_q + 6'h01;
  assign cmp.pfm_ok = light_full; // [R07]

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      div_q <= TICK_RST;
      light_q <= LIGHT_CNT_RST;
    end else begin
      div_q <= div_d;
      light_q <= light_d;
    end
  end
endmodule
`default_nettype wire

// ### hw/bpsc_soft_start.sv
`timescale 1ns/100ps
`default_nettype none
module bpsc_soft_start
  import bpsc_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic supply_ok_i,
  input wire logic step_i,
  output logic [1:0] ilim_sel_o
);
  logic en_prev_q;
  logic [1:0] sel_q;
  logic [1:0] sel_d;
  logic [SS_CNT_W-1:0] cnt_q;
  logic [SS_CNT_W-1:0] cnt_d;
  logic start;
  logic advance;

  // Only a rising enable with supply above start level restarts the ramp [R16]
  assign start = enable_i && !en_prev_q && supply_ok_i;
  assign advance = step_i && (cnt_q == SS_CNT_LAST) && (sel_q != ILIM_SEL_FULL);
  assign cnt_d = start ? SS_CNT_RST :
                 !step_i ? cnt_q :
                 (cnt_q == SS_CNT_LAST) ? SS_CNT_RST : cnt_q + 5'h01;
  assign sel_d = start ? ILIM_SEL_200 : advance ? sel_q + 2'h1 : sel_q; // [R16]
  assign ilim_sel_o = sel_q;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      en_prev_q <= 1'b0;
      sel_q <= ILIM_SEL_FULL;
      cnt_q <= SS_CNT_RST;
    end else begin
      en_prev_q <= enable_i;
      sel_q <= sel_d;
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// ### hw/bpsc_switch_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// Contract
// R01: PWM turns high side on each tick
// R02: Duty or current-limit trip ends high side
// R03: Low side after high; tick ends it
// R04: Low side rectifies in PWM off time
// R05: Current-limit trip ends that cycle's conduction
// R06: Short holds low side until current low
// R07: 32 light cycles move PWM into PFM
// R08: PFM high side until high threshold or peak
// R09: PFM low side until zero current, repeat
// R10: At high threshold park current, then sleep
// R11: Below low2 threshold return to PWM; BPSC_PFM_PARK ignores it and waits for zero current, then BPSC_SLEEP returns
// R12: Each output own enable; all low shutdown
// R13: Undervoltage lockout gates device operation
// R14: Buck off: post-regulator on small pass
// R15: Buck on: post-regulator on large pass
// R16: Soft start ramps limit on enable rise
// R17: Heavy cycle restarts light-load counter
module bpsc_switch_ctrl (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic buck_enable_i,
  input wire logic post_reg_enable_i,
  input wire logic low_noise_reg_enable_i,
  input wire logic uvlo_start_i,
  input wire logic uvlo_stop_i,
  input wire logic supply_ss_ok_i,
  input wire logic duty_trip_i,
  input wire logic ilim_trip_i,
  input wire logic short_det_i,
  input wire logic il_low_i,
  input wire logic nfet_zero_i,
  input wire logic below_imode_i,
  input wire logic below_pfm_high_i,
  input wire logic light_load_peak_current_i,
  input wire logic below_pfm_low2_i,
  output logic hs_on_o,
  output logic ls_on_o,
  output logic pfm_mode_o,
  output logic sleep_o,
  output logic shutdown_o,
  output logic buck_on_o,
  output logic post_reg_on_o,
  output logic post_reg_large_o,
  output logic low_noise_reg_on_o,
  output logic [1:0] ilim_sel_o
);
  import bpsc_pkg::*;

  bpsc_state_t state_q;
  bpsc_state_t state_d;
  logic supply_ok_q;
  logic supply_ok_d;
  logic hs_q;
  logic ls_q;
  logic hs_d;
  logic ls_d;
  logic cyc_light_q;
  logic cyc_light_d;
  logic buck_on_request;
  logic run;
  logic pwm_end;
  logic light_now;
  logic tick;
  logic pfm_ok;
  logic in_pwm;

  bpsc_cmp_if cmp ();

  // Lockout with hysteresis between start and stop levels [R13]
  assign supply_ok_d = uvlo_stop_i ? 1'b0 : uvlo_start_i ? 1'b1 : supply_ok_q;
  assign buck_on_request = buck_enable_i && supply_ok_q; // [R12] [R13]
  assign run = buck_on_request;
  assign pwm_end = duty_trip_i || ilim_trip_i; // [R02] [R05]
  assign light_now = nfet_zero_i || below_imode_i;
  assign tick = cmp.tick;
  assign pfm_ok = cmp.pfm_ok;
  assign in_pwm = (state_q == BPSC_PWM_HS) || (state_q == BPSC_PWM_LS);
  // Outside PWM every clock clears the count, so a PFM visit cannot leave it full [R07] [R17]
  assign cmp.cycle_start = tick || !in_pwm;
  assign cmp.light_cycle = cyc_light_q && in_pwm;

  bpsc_tick_gen u_tick (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .run_i(run),
    .cmp(cmp)
  );

  bpsc_soft_start u_ss (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .enable_i(buck_enable_i),
    .supply_ok_i(supply_ss_ok_i),
    .step_i(tick),
    .ilim_sel_o(ilim_sel_o)
  );

  // Light flag collected over one PWM cycle, cleared at tick
  assign cyc_light_d = !run ? 1'b0 : tick ? 1'b0 : (cyc_light_q || light_now);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      BPSC_OFF: begin
        if (run) begin
          state_d = BPSC_PWM_HS;
        end
      end
      BPSC_PWM_HS: begin
        if (pwm_end) begin
          state_d = BPSC_PWM_LS; // [R02] [R03] [R05]
        end
      end
      BPSC_PWM_LS: begin
        if (short_det_i) begin
          state_d = BPSC_LIMIT; // [R06]
        end else if (tick && pfm_ok) begin
          state_d = BPSC_PFM_HS; // [R07]
        end else if (tick) begin
          state_d = BPSC_PWM_HS; // [R01] [R03]
        end
      end
      BPSC_LIMIT: begin
        if (il_low_i) begin
          state_d = BPSC_PWM_HS; // [R06]
        end
      end
      BPSC_PFM_HS: begin
        if (below_pfm_low2_i) begin
          state_d = BPSC_PWM_HS; // [R11]
        end else if (!below_pfm_high_i || light_load_peak_current_i) begin
          state_d = BPSC_PFM_LS; // [R08]
        end
      end
      BPSC_PFM_LS: begin
        if (below_pfm_low2_i) begin
          state_d = BPSC_PWM_HS; // [R11]
        end else if (nfet_zero_i && below_pfm_high_i) begin
          state_d = BPSC_PFM_HS; // [R09]
        end else if (!below_pfm_high_i) begin
          state_d = BPSC_PFM_PARK; // [R10]
        end
      end
      BPSC_PFM_PARK: begin
        if (nfet_zero_i) begin
          state_d = BPSC_SLEEP; // [R10]
        end
      end
      BPSC_SLEEP: begin
        if (below_pfm_low2_i) begin
          state_d = BPSC_PWM_HS; // [R11]
        end else if (below_pfm_high_i) begin
          state_d = BPSC_PFM_HS; // [R08]
        end
      end
    endcase
    // Disable or lockout overrides everything [R12] [R13]
    if (!run) begin
      state_d = BPSC_OFF;
    end
  end

  // Registered gates; never both on, so no shoot-through [R03] [R04]
  assign hs_d = (state_d == BPSC_PWM_HS) || (state_d == BPSC_PFM_HS);
  assign ls_d = (state_d == BPSC_PWM_LS) || (state_d == BPSC_LIMIT) ||
                (state_d == BPSC_PFM_LS) || (state_d == BPSC_PFM_PARK); // [R04] [R06] [R09] [R10]

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_q <= BPSC_OFF;
      supply_ok_q <= 1'b0;
      hs_q <= 1'b0;
      ls_q <= 1'b0;
      cyc_light_q <= 1'b0;
    end else begin
      state_q <= state_d;
      supply_ok_q <= supply_ok_d;
      hs_q <= hs_d;
      ls_q <= ls_d;
      cyc_light_q <= cyc_light_d;
    end
  end

  assign hs_on_o = hs_q;
  assign ls_on_o = ls_q;
  assign pfm_mode_o = state_q[2];
  assign sleep_o = (state_q == BPSC_SLEEP); // [R10]
  assign buck_on_o = buck_on_request;
  assign post_reg_on_o = post_reg_enable_i && supply_ok_q; // [R12]
  assign post_reg_large_o = post_reg_on_o && buck_on_request; // [R14] [R15]
  assign low_noise_reg_on_o = low_noise_reg_enable_i && supply_ok_q; // [R12]
  assign shutdown_o = !(buck_enable_i || post_reg_enable_i || low_noise_reg_enable_i); // [R12]
endmodule
`default_nettype wire

// ### testbench/bpsc_stage_model.sv
`timescale 1ns/100ps
`default_nettype none
module bpsc_stage_model (
  input wire logic clock_i,
  input wire logic hs_on_i,
  input wire logic ls_on_i,
  input wire logic light_i,
  output logic duty_trip_o,
  output logic nfet_zero_o,
  output logic below_imode_o
);
  logic [1:0] on_q;
  // Short ramp keeps each trip well inside one tick
  always_ff @(posedge clock_i) on_q <= hs_on_i ? on_q + 2'h1 : 2'h0;
  assign duty_trip_o = hs_on_i && on_q == 2'h3;
  // Light load empties the coil while the low side conducts
  assign nfet_zero_o = light_i && ls_on_i;
  assign below_imode_o = light_i;
endmodule
`default_nettype wire

// ### testbench/bpsc_sc_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module bpsc_sc_asserts (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic uvlo_stop_i,
  input wire logic duty_trip_i,
  input wire logic ilim_trip_i,
  input wire logic short_det_i,
  input wire logic il_low_i,
  input wire logic below_pfm_high_i,
  input wire logic light_load_peak_current_i,
  input wire logic below_pfm_low2_i,
  input wire logic hs_on_o,
  input wire logic ls_on_o,
  input wire logic pfm_mode_o,
  input wire logic sleep_o,
  input wire logic buck_on_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // Lockout may end a phase early, so it is excluded
  wire run = buck_on_o && !uvlo_stop_i;
  property p_ov;
    !(hs_on_o && ls_on_o);
  endproperty
  a_ov: assert property (p_ov) else $error("gates overlap");
  property p_duty;
    hs_on_o && !pfm_mode_o && duty_trip_i && run |=> !hs_on_o && ls_on_o;
  endproperty
  a_duty: assert property (p_duty) else $error("duty trip");
  property p_ilim;
    hs_on_o && !pfm_mode_o && ilim_trip_i && run |=> !hs_on_o && ls_on_o;
  endproperty
  a_ilim: assert property (p_ilim) else $error("limit trip");
  property p_short;
    ls_on_o && !pfm_mode_o && short_det_i && !il_low_i && run |=> ls_on_o && !hs_on_o;
  endproperty
  a_short: assert property (p_short) else $error("short hold");
  property p_pfmhs;
    pfm_mode_o && hs_on_o && (light_load_peak_current_i || !below_pfm_high_i) && !below_pfm_low2_i && run
      |=> ls_on_o && !hs_on_o;
  endproperty
  a_pfmhs: assert property (p_pfmhs) else $error("pfm high side");
  property p_sleep;
    sleep_o |-> !hs_on_o && !ls_on_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep gates");
  property p_low2;
    pfm_mode_o && (hs_on_o || sleep_o) && below_pfm_low2_i && run |=> hs_on_o && !pfm_mode_o;
  endproperty
  a_low2: assert property (p_low2) else $error("low2 exit");
  property p_uvlo;
    uvlo_stop_i |=> !buck_on_o;
  endproperty
  a_uvlo: assert property (p_uvlo) else $error("lockout");
endmodule
bind bpsc_switch_ctrl bpsc_sc_asserts u_chk (.*);
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin err_count++; $display("BAD %s exp %0h got %0h", n, e, s); end end
`define WT(c) begin for (int k = 0; k < 600 && !(c); k++) @(negedge clk); if (!(c)) begin err_count++; conclude(); end end
module tb;
  import bpsc_pkg::*;
  logic clk, rst, ben, pen, len, up, down, ssok, ilim, shrt, ill, hi, peak, low2, light;
  logic duty, zero, imode, hs, ls, pfm, slp, shd, bon, pon, plg, lon;
  logic [1:0] sel;
  int err_count;
  int check_count;
  bpsc_switch_ctrl dut (.clock_i(clk), .rst_i(rst), .buck_enable_i(ben), .post_reg_enable_i(pen),
    .low_noise_reg_enable_i(len), .uvlo_start_i(up), .uvlo_stop_i(down), .supply_ss_ok_i(ssok),
    .duty_trip_i(duty), .ilim_trip_i(ilim), .short_det_i(shrt), .il_low_i(ill), .nfet_zero_i(zero),
    .below_imode_i(imode), .below_pfm_high_i(hi), .light_load_peak_current_i(peak),
    .below_pfm_low2_i(low2), .hs_on_o(hs), .ls_on_o(ls), .pfm_mode_o(pfm), .sleep_o(slp),
    .shutdown_o(shd), .buck_on_o(bon), .post_reg_on_o(pon), .post_reg_large_o(plg),
    .low_noise_reg_on_o(lon), .ilim_sel_o(sel));
  bpsc_stage_model u_stage (.clock_i(clk), .hs_on_i(hs), .ls_on_i(ls), .light_i(light),
    .duty_trip_o(duty), .nfet_zero_o(zero), .below_imode_o(imode));
  task automatic conclude();
    if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_pwm();
    ben = 1;
    `WT(hs)
    `CHK("ilim_sel", ILIM_SEL_200, sel)
    `CHK("shutdown", 1'b0, shd)
    `WT(ls)
    `CHK("hs after trip", 1'b0, hs)
    `WT(hs)
    `CHK("ls at tick", 1'b0, ls)
    ilim = 1;
    @(negedge clk);
    ilim = 0;
    `CHK("ls after limit", 1'b1, ls)
    shrt = 1;
    repeat (20) @(negedge clk);
    `CHK("ls in limit", 1'b1, ls)
    shrt = 0;
    ill = 1;
    @(negedge clk);
    ill = 0;
    `CHK("hs after decay", 1'b1, hs)
  endtask
  task automatic t_pfm();
    light = 1;
    hi = 1;
    repeat (280) @(negedge clk);
    `CHK("ilim_sel step", ILIM_SEL_400, sel)
    light = 0;
    repeat (28) @(negedge clk);
    light = 1;
    repeat (392) @(negedge clk);
    `CHK("pfm early", 1'b0, pfm)
    `CHK("ilim_sel full", ILIM_SEL_FULL, sel)
    `WT(pfm)
    `CHK("pfm entry", 1'b1, pfm)
    `WT(hs)
    peak = 1;
    @(negedge clk);
    peak = 0;
    `CHK("pfm peak end", 1'b1, ls)
    `WT(hs)
    `CHK("pfm repeat", 1'b0, ls)
    hi = 0;
    `WT(slp)
    `CHK("sleep gates", 2'h0, {hs, ls})
    low2 = 1;
    @(negedge clk);
    low2 = 0;
    `CHK("back to pwm", 2'h1, {pfm, hs})
    light = 0;
    hi = 1;
    repeat (20) @(negedge clk);
    `CHK("heavy stays pwm", 1'b0, pfm)
  endtask
  task automatic t_en();
    pen = 1;
    len = 1;
    @(negedge clk);
    `CHK("large pass", 3'h7, {pon, plg, lon})
    ben = 0;
    @(negedge clk);
    `CHK("small pass", 3'h5, {pon, plg, lon})
    ben = 1;
    down = 1;
    repeat (2) @(negedge clk);
    `CHK("lockout", 3'h0, {bon, hs, ls})
    `CHK("ilim_sel restart", ILIM_SEL_200, sel)
    ben = 0;
    pen = 0;
    len = 0;
    @(negedge clk);
    `CHK("shutdown", 1'b1, shd)
  endtask
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {rst, ben, pen, len, up, down, ssok, ilim, shrt, ill, hi, peak, low2, light} = 14'h2000;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 0;
    up = 1;
    ssok = 1;
    @(negedge clk);
    t_pwm();
    t_pfm();
    t_en();
    conclude();
  end
endmodule
`default_nettype wire
